// file: rtl/sic_device.sv
// Overview of operation
// - bits 3:0 set serial output swing
// - bit 4 inverts loop clock output
// - bit 5 inverts loop data output
// - bit 6 picks AC or DC coupling
// - bit 7 swaps loop clock/data pairs
// - serial config at CBH, resets 03H
// - mask bit 0 gates lock loss event
// - mask bit 4 gates overheat event
// - mask bit 5 gates fifo overrun event
// - bit 6 pin polarity, bit 7 drive
// - mask at CCH, reset 50H, reserved zero
// - timing register FDH selects 10:1 range
// - mode pin picks registers or straps
// - three pins pick eight bit rates
// - two pins pick multiplex ratio
// - one pin picks clocking direction
// - two pins configure loop in/out
// - one pin picks parity sense
// - strap mode keeps indications, overheat open-drain
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module sic_device (
  input wire logic clk,
  input wire logic reset,
  sic_if.device link,
  input wire logic lock_loss_event,
  input wire logic overheat_event,
  input wire logic fifo_overrun_event,
  output logic [3:0] serial_swing_code,
  output logic loop_clock_out_invert,
  output logic loop_data_out_invert,
  output logic serial_out_coupling,
  output logic loop_pair_exchange,
  output logic [7:0] ten_to_one_rate_range,
  output logic [2:0] rate_sel_out,
  output logic [1:0] ratio_sel_out,
  output logic clk_dir_out,
  output logic loop_in_en_out,
  output logic loop_out_en_out,
  output logic parity_odd_out,
  output logic fifo_clear_out,
  output logic host_controlled
);
  import sic_pkg::*;

  logic [7:0] serial_cfg_q;
  logic [7:0] irq_cfg_q;
  logic [7:0] timing_q;
  logic [7:0] rdata_q;
  logic err_q;
  logic irq_active;
  logic irq_level;
  logic push_pull;
  logic active_low;

  // ==========================================
  // register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_cfg_q <= SIC_RST_SERIAL_CFG;
    end else if (link.reg_wr && link.reg_addr == SIC_ADDR_SERIAL_CFG) begin
      serial_cfg_q <= link.reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_cfg_q <= SIC_RST_IRQ_CFG;
    end else if (link.reg_wr && link.reg_addr == SIC_ADDR_IRQ_CFG) begin
      irq_cfg_q <= link.reg_wdata & ~SIC_IRQ_RSVD_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timing_q <= SIC_RST_TIMING;
    end else if (link.reg_wr && link.reg_addr == SIC_ADDR_TIMING) begin
      timing_q <= link.reg_wdata;
    end
  end

  // ==========================================
  // reads: one cycle latency, unmapped flags error
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      err_q <= 1'b0;
      if (link.reg_rd || link.reg_wr) begin
        case (link.reg_addr)
          SIC_ADDR_SERIAL_CFG: rdata_q <= serial_cfg_q;
          SIC_ADDR_IRQ_CFG: rdata_q <= irq_cfg_q;
          SIC_ADDR_TIMING: rdata_q <= timing_q;
          default: begin
            rdata_q <= 8'h00;
            err_q <= 1'b1;
          end
        endcase
      end
    end
  end
  assign link.reg_rdata = rdata_q;
  assign link.reg_err = err_q;

  // ==========================================
  // control source selection
  assign host_controlled = link.host_mode_select;
  assign serial_swing_code = host_controlled ?
      serial_cfg_q[SIC_SWING_LSB +: SIC_SWING_W] : SIC_RST_SERIAL_CFG[SIC_SWING_LSB +: SIC_SWING_W];
  assign loop_clock_out_invert = host_controlled & serial_cfg_q[SIC_LOOP_CLK_INV];
  assign loop_data_out_invert = host_controlled & serial_cfg_q[SIC_LOOP_DAT_INV];
  // strap mode runs the serial output dc-coupled
  assign serial_out_coupling = host_controlled & serial_cfg_q[SIC_OUT_COUPLING];
  assign loop_pair_exchange = host_controlled & serial_cfg_q[SIC_LOOP_SWAP];
  assign ten_to_one_rate_range = host_controlled ? timing_q : SIC_RST_TIMING;
  // rate and ratio regs live outside this block; straps pass only in pin mode
  assign rate_sel_out = host_controlled ? 3'h0 : link.rate_select;
  assign ratio_sel_out = host_controlled ? 2'h0 : link.ratio_select;
  assign clk_dir_out = host_controlled ? 1'b0 : link.clocking_direction_select;
  assign loop_in_en_out = !host_controlled && !link.loop_input_enable_n;
  assign loop_out_en_out = !host_controlled && !link.loop_output_enable_n;
  assign parity_odd_out = !host_controlled && !link.parity_sense_select;
  assign fifo_clear_out = link.fifo_clear;

  // ==========================================
  // indications and interrupt pin
  assign link.lock_lost = lock_loss_event;
  assign link.fifo_overrun = fifo_overrun_event;
  always_comb begin
    if (host_controlled) begin
      irq_active = (lock_loss_event & irq_cfg_q[SIC_LOCK_EN])
          | (overheat_event & irq_cfg_q[SIC_HEAT_EN])
          | (fifo_overrun_event & irq_cfg_q[SIC_FIFO_EN]);
      active_low = irq_cfg_q[SIC_IRQ_POL];
      push_pull = irq_cfg_q[SIC_IRQ_DRIVE];
    end else begin
      // pin mode: overheat only, open-drain, active low
      irq_active = overheat_event;
      active_low = 1'b1;
      push_pull = 1'b0;
    end
  end
  assign irq_level = irq_active ^ active_low;
  // open-drain only pulls low; high level left to the pull-up
  assign link.irq_pin_out = irq_level;
  assign link.irq_pin_oe = push_pull | ~irq_level;
endmodule : sic_device
`default_nettype wire

// file: rtl/sic_pkg.sv
`default_nettype none
package sic_pkg;
  // ==========================================
  // register addresses
  localparam logic [7:0] SIC_ADDR_SERIAL_CFG = 8'hCB;
  localparam logic [7:0] SIC_ADDR_IRQ_CFG = 8'hCC;
  localparam logic [7:0] SIC_ADDR_TIMING = 8'hFD;
  // ==========================================
  // reset values
  localparam logic [7:0] SIC_RST_SERIAL_CFG = 8'h03;
  localparam logic [7:0] SIC_RST_IRQ_CFG = 8'h50;
  localparam logic [7:0] SIC_RST_TIMING = 8'h80;
  // ==========================================
  // field positions
  localparam int SIC_SWING_LSB = 0;
  localparam int SIC_SWING_W = 4;
  localparam int SIC_LOOP_CLK_INV = 4;
  localparam int SIC_LOOP_DAT_INV = 5;
  localparam int SIC_OUT_COUPLING = 6;
  localparam int SIC_LOOP_SWAP = 7;
  localparam int SIC_LOCK_EN = 0;
  localparam int SIC_HEAT_EN = 4;
  localparam int SIC_FIFO_EN = 5;
  localparam int SIC_IRQ_POL = 6;
  localparam int SIC_IRQ_DRIVE = 7;
  localparam logic [7:0] SIC_IRQ_RSVD_MASK = 8'h0E;
  localparam logic [7:0] SIC_RANGE_3G2 = 8'h04;
  localparam logic [7:0] SIC_RANGE_2G7 = 8'h08;
  // ==========================================
  // host APB register map (byte addresses)
  localparam logic [7:0] SIC_APB_CTRL = 8'h00;
  localparam logic [7:0] SIC_APB_STRAP = 8'h04;
  localparam logic [7:0] SIC_APB_STATUS = 8'h08;
  localparam logic [7:0] SIC_APB_RDATA = 8'h0C;
  localparam logic [7:0] SIC_APB_GO = 8'h10;
  // ==========================================
  // strap word layout: rate[2:0] ratio[4:3] dir[5] lin_n[6] lout_n[7] par[8]
  localparam int SIC_STRAP_W = 9;
  // ==========================================
  // ctrl word layout: addr[7:0] wdata[15:8] write[16] host mode[17] fifo clear[18]
  localparam logic [31:0] SIC_CTRL_RST = 32'h0002_0000;
  localparam int SIC_CTRL_WR = 16;
  localparam int SIC_CTRL_HOST = 17;
  localparam int SIC_CTRL_FCLR = 18;
endpackage : sic_pkg
`default_nettype wire

// file: rtl/sic_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sic_if;
  logic host_mode_select;
  logic [2:0] rate_select;
  logic [1:0] ratio_select;
  logic clocking_direction_select;
  logic loop_input_enable_n;
  logic loop_output_enable_n;
  logic parity_sense_select;
  logic fifo_clear;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_err;
  logic lock_lost;
  logic fifo_overrun;
  logic irq_pin_out;
  logic irq_pin_oe;
  logic irq_pin;
  // open-drain resolves with pull-up when not driven
  assign irq_pin = irq_pin_oe ? irq_pin_out : 1'b1;
  modport device (
    input host_mode_select, rate_select, ratio_select, clocking_direction_select,
    input loop_input_enable_n, loop_output_enable_n, parity_sense_select, fifo_clear,
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_err, lock_lost, fifo_overrun, irq_pin_out, irq_pin_oe
  );
  modport host (
    output host_mode_select, rate_select, ratio_select, clocking_direction_select,
    output loop_input_enable_n, loop_output_enable_n, parity_sense_select, fifo_clear,
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_err, lock_lost, fifo_overrun, irq_pin
  );
endinterface : sic_if
`default_nettype wire

// file: rtl/sic_host.sv
`timescale 1ns/1ns
`default_nettype none
module sic_host (
  input wire logic clk,
  input wire logic reset,
  sic_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import sic_pkg::*;

  typedef enum logic [1:0] {SIC_IDLE, SIC_ISSUE, SIC_WAIT} sic_state_t;
  sic_state_t state_q;
  logic [31:0] ctrl_q;
  logic [SIC_STRAP_W-1:0] strap_q;
  logic [7:0] rdata_q;
  logic err_q;
  logic wr_go;
  logic rd_go;
  logic access;

  assign access = psel && penable;
  assign wr_go = access && pwrite && paddr == SIC_APB_GO;
  // ctrl: [7:0] reg addr, [15:8] wdata, [16] write, [17] host mode, [18] fifo clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= SIC_CTRL_RST;
    end else if (access && pwrite && paddr == SIC_APB_CTRL) begin
      ctrl_q <= pwdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_q <= '0;
    end else if (access && pwrite && paddr == SIC_APB_STRAP) begin
      strap_q <= pwdata[SIC_STRAP_W-1:0];
    end
  end

  // ==========================================
  // register transfer sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SIC_IDLE;
    end else begin
      case (state_q)
        SIC_IDLE: if (wr_go) state_q <= SIC_ISSUE;
        SIC_ISSUE: state_q <= SIC_WAIT;
        SIC_WAIT: state_q <= SIC_IDLE;
        default: state_q <= SIC_IDLE;
      endcase
    end
  end
  assign rd_go = state_q == SIC_ISSUE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      err_q <= 1'b0;
    end else if (state_q == SIC_WAIT) begin
      rdata_q <= link.reg_rdata;
      err_q <= link.reg_err;
    end
  end

  assign link.reg_addr = ctrl_q[7:0];
  assign link.reg_wdata = ctrl_q[15:8];
  assign link.reg_wr = rd_go && ctrl_q[SIC_CTRL_WR];
  assign link.reg_rd = rd_go && !ctrl_q[SIC_CTRL_WR];
  assign link.host_mode_select = ctrl_q[SIC_CTRL_HOST];
  assign link.fifo_clear = ctrl_q[SIC_CTRL_FCLR];
  assign link.rate_select = strap_q[2:0];
  assign link.ratio_select = strap_q[4:3];
  assign link.clocking_direction_select = strap_q[5];
  assign link.loop_input_enable_n = strap_q[6];
  assign link.loop_output_enable_n = strap_q[7];
  assign link.parity_sense_select = strap_q[8];

  // ==========================================
  // apb answer: zero wait, status shows busy, error, pins
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    case (paddr)
      SIC_APB_CTRL: prdata = ctrl_q;
      SIC_APB_STRAP: prdata = {{(32 - SIC_STRAP_W){1'b0}}, strap_q};
      SIC_APB_STATUS: prdata = {27'h0, link.irq_pin, link.fifo_overrun, link.lock_lost,
          err_q, state_q != SIC_IDLE};
      SIC_APB_RDATA: prdata = {24'h0, rdata_q};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule : sic_host
`default_nettype wire

// file: verif/sic_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sic_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_mode_select,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_err,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  import sic_pkg::*;
  // ==========================================
  // shadow registers
  logic [7:0] cb_q, cc_q, fd_q;
  logic hit;
  assign hit = reg_addr inside {SIC_ADDR_SERIAL_CFG, SIC_ADDR_IRQ_CFG, SIC_ADDR_TIMING};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cb_q <= SIC_RST_SERIAL_CFG;
      cc_q <= SIC_RST_IRQ_CFG;
      fd_q <= SIC_RST_TIMING;
    end else if (reg_wr) begin
      if (reg_addr == SIC_ADDR_SERIAL_CFG) cb_q <= reg_wdata;
      if (reg_addr == SIC_ADDR_IRQ_CFG) cc_q <= reg_wdata & ~SIC_IRQ_RSVD_MASK;
      if (reg_addr == SIC_ADDR_TIMING) fd_q <= reg_wdata;
    end
  end
  // ==========================================
  // properties
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  property p_unmapped;
    (reg_rd || reg_wr) && !hit |=> reg_err;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  property p_mapped;
    reg_rd && hit |=> !reg_err;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read flagged");
  property p_serial_rb;
    reg_rd && reg_addr == SIC_ADDR_SERIAL_CFG |=> reg_rdata == $past(cb_q);
  endproperty
  a_serial_rb: assert property (p_serial_rb) else $error("serial config readback");
  property p_irq_rb;
    reg_rd && reg_addr == SIC_ADDR_IRQ_CFG |=> reg_rdata == $past(cc_q);
  endproperty
  a_irq_rb: assert property (p_irq_rb) else $error("irq config readback");
  property p_timing_rb;
    reg_rd && reg_addr == SIC_ADDR_TIMING |=> reg_rdata == $past(fd_q);
  endproperty
  a_timing_rb: assert property (p_timing_rb) else $error("timing readback");
  property p_pin_od;
    !host_mode_select |-> irq_pin_oe == !irq_pin_out;
  endproperty
  a_pin_od: assert property (p_pin_od) else $error("pin mode irq not open drain");
  property p_push_pull;
    host_mode_select && cc_q[SIC_IRQ_DRIVE] |-> irq_pin_oe;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("irq driver off");
  property p_open_drain;
    host_mode_select && !cc_q[SIC_IRQ_DRIVE] |-> irq_pin_oe == !irq_pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("irq drives high");
  property p_idle;
    host_mode_select && (cc_q & 8'h31) == 8'h00 |-> irq_pin_out == cc_q[SIC_IRQ_POL];
  endproperty
  a_idle: assert property (p_idle) else $error("irq active with all masked");
endmodule : sic_checker
`default_nettype wire

// file: verif/serial_io_interrupt_config_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_io_interrupt_config_test;
  import sic_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] ev;
  logic [3:0] swing;
  logic cinv, dinv, coup, swap, dir, lin, lout, podd, fclr, hostc;
  logic [7:0] range;
  logic [2:0] rate;
  logic [1:0] ratio;
  logic [7:0] ra [3] = '{SIC_ADDR_SERIAL_CFG, SIC_ADDR_IRQ_CFG, SIC_ADDR_TIMING};
  logic [7:0] rv [3] = '{8'h03, 8'h50, 8'h80};
  logic [7:0] pv [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
  logic [7:0] en [3] = '{8'h01, 8'h10, 8'h20};
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  sic_if sic_if_i ();
  sic_host sic_host_i (.clk(clk), .reset(reset), .link(sic_if_i.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sic_device sic_device_i (.clk(clk), .reset(reset), .link(sic_if_i.device),
    .lock_loss_event(ev[0]), .overheat_event(ev[1]), .fifo_overrun_event(ev[2]),
    .serial_swing_code(swing), .loop_clock_out_invert(cinv), .loop_data_out_invert(dinv),
    .serial_out_coupling(coup), .loop_pair_exchange(swap), .ten_to_one_rate_range(range),
    .rate_sel_out(rate), .ratio_sel_out(ratio), .clk_dir_out(dir), .loop_in_en_out(lin),
    .loop_out_en_out(lout), .parity_odd_out(podd), .fifo_clear_out(fclr),
    .host_controlled(hostc));
  sic_checker sic_checker_i (.clk(clk), .reset(reset),
    .host_mode_select(sic_if_i.host_mode_select), .reg_wr(sic_if_i.reg_wr),
    .reg_rd(sic_if_i.reg_rd), .reg_addr(sic_if_i.reg_addr), .reg_wdata(sic_if_i.reg_wdata),
    .reg_rdata(sic_if_i.reg_rdata), .reg_err(sic_if_i.reg_err),
    .irq_pin_out(sic_if_i.irq_pin_out), .irq_pin_oe(sic_if_i.irq_pin_oe));
  // ==========================================
  // bus tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    logic ok;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // sample the settled answer before the edge that takes it, not after it
    do begin
      @(negedge clk);
      ok = pready;
      q = prdata;
      @(posedge clk);
    end while (ok !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // busy drops only once rdata and err are held by the host
  task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    logic [31:0] r;
    apb(1'h1, SIC_APB_CTRL, {14'h0, 1'h1, wr, d, a}, r);
    apb(1'h1, SIC_APB_GO, 32'h0, r);
    do apb(1'h0, SIC_APB_STATUS, 32'h0, r); while (r[0] !== 1'h0);
    apb(1'h0, SIC_APB_RDATA, 32'h0, r);
    q = r[7:0];
    apb(1'h0, SIC_APB_STATUS, 32'h0, r);
    e = r[1];
  endtask : dev
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // about 22 device register operations; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    logic [7:0] q;
    logic e;
    logic [31:0] r;
    logic [8:0] s;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 3'h0;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    chk({swap, coup, dinv, cinv, swing, range}, 16'h0380);
    chk({hostc, podd, lout, lin, dir, ratio, rate}, 10'h200);
    for (int i = 0; i < 3; i++) begin
      dev(1'h0, ra[i], 8'h00, q, e);
      chk({e, q}, {1'h0, rv[i]});
    end
    foreach (pv[i]) begin
      dev(1'h1, SIC_ADDR_SERIAL_CFG, pv[i], q, e);
      chk({swap, coup, dinv, cinv, swing}, pv[i]);
      dev(1'h0, SIC_ADDR_SERIAL_CFG, 8'h00, q, e);
      chk(q, pv[i]);
    end
    dev(1'h1, SIC_ADDR_IRQ_CFG, 8'hFF, q, e);
    dev(1'h0, SIC_ADDR_IRQ_CFG, 8'h00, q, e);
    chk(q, 8'hF1);
    dev(1'h1, 8'h00, 8'h12, q, e);
    chk(e, 1'h1);
    apb(1'h0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    dev(1'h1, SIC_ADDR_TIMING, SIC_RANGE_3G2, q, e);
    chk(range, SIC_RANGE_3G2);
    dev(1'h1, SIC_ADDR_TIMING, SIC_RANGE_2G7, q, e);
    chk(range, SIC_RANGE_2G7);
    for (int i = 0; i < 3; i++) begin
      dev(1'h1, SIC_ADDR_IRQ_CFG, 8'h80 | en[i], q, e);
      ev <= ~(3'h1 << i);
      @(posedge clk);
      chk(sic_if_i.irq_pin, 1'h0);
      ev <= 3'h1 << i;
      @(posedge clk);
      chk(sic_if_i.irq_pin, 1'h1);
      dev(1'h1, SIC_ADDR_IRQ_CFG, 8'hC0 | en[i], q, e);
      chk(sic_if_i.irq_pin, 1'h0);
      ev <= 3'h0;
    end
    apb(1'h1, SIC_APB_CTRL, 32'h00040000, r);
    @(posedge clk);
    chk({hostc, fclr, swap, coup, dinv, cinv, swing, range}, 18'h10380);
    for (int i = 0; i < 8; i++) begin
      s = {i[0], i[1], i[2], i[0], i[1:0], i[2:0]};
      apb(1'h1, SIC_APB_STRAP, {23'h0, s}, r);
      @(posedge clk);
      chk({podd, lout, lin, dir, ratio, rate}, {~s[8:6], s[5:0]});
    end
    ev <= 3'h2;
    @(posedge clk);
    chk(sic_if_i.irq_pin, 1'h0);
    ev <= 3'h5;
    @(posedge clk);
    chk({sic_if_i.irq_pin, sic_if_i.lock_lost, sic_if_i.fifo_overrun}, 3'h7);
    apb(1'h0, SIC_APB_STATUS, 32'h0, r);
    chk({pready, pslverr, r[29:0]}, {2'h2, 30'h0000_001C});
    test_done();
  end
endmodule : serial_io_interrupt_config_test
`default_nettype wire
